// >>> pkg/tpc_pkg.sv
// constants for the timer with compare/capture/pwm channels
// assumes one bus clock, byte-wide registers on aligned 32-bit words
// Operation
// - up mode counts zero to terminal count, then wraps to zero.
// - centered mode counts up to terminal, down to zero; ends last one tick.
// - centered mode sets wrap flag when stepping down from terminal count.
// - any counter byte write zeroes the counter and its read latch.
// - with centering off each channel picks capture, compare or edge pwm.
// - capture copies counter to channel value on selected pin edge.
// - channel value bytes ignore writes while in capture mode.
// - reading one value byte buffers the other; status write resets it.
// - capture sets channel flag; flag with enable raises interrupt.
// - during debug halt capture still works with frozen counter.
// - compare match sets, clears or toggles pin and sets flag.
// - compare value loads after both bytes: at once if stopped, else next tick.
// - edge pwm period is modulus plus one ticks, duty from channel value.
// - edge pwm: wrap drives active, match inactive; polarity bit inverts.
// - edge pwm value zero gives 0%, above modulus gives 100%.
// - pwm value loads when counter steps from terminal minus one to terminal.
// - centered pwm pulse is twice value, period twice modulus.
// - centered pwm value zero or negative gives 0%; above modulus 100%.
// - centered pwm: up match drives low, down match high; polarity inverts.
// - status writes discard pending modulus or channel value byte writes.
// - reset clears control: clock off, all channels capture, pins released.
// - clock select: off, bus clock, fixed clock, external pin; counter kept.
// - free running up mode sets wrap flag passing maximum to zero.
// - flag clears by read while set then write zero; new event keeps it.
package tpc_pkg;
    localparam int TPC_NCH = 2;
    // word indexes, byte address is four times the index
    localparam logic [5:0] IDX_SC = 6'h00;
    localparam logic [5:0] IDX_CNTH = 6'h01;
    localparam logic [5:0] IDX_CNTL = 6'h02;
    localparam logic [5:0] IDX_MODH = 6'h03;
    localparam logic [5:0] IDX_MODL = 6'h04;
    localparam logic [5:0] IDX_CH0 = 6'h05;
    localparam int CH_STRIDE = 3;
    localparam logic [5:0] IDX_NONE = 6'h3F;
    localparam logic [23:0] ADDR_HI_ZERO = 24'h000000;
    // timer status/control fields
    localparam int SC_FLAG = 7;
    localparam int SC_IE = 6;
    localparam int SC_CENTER_ALIGN_SELECT = 5;
    localparam int SC_CLKS = 3;
    // channel status/control fields
    localparam int CH_FLAG = 7;
    localparam int CH_IE = 6;
    localparam int CH_MSB = 5;
    localparam int CH_MSA = 4;
    localparam int CH_ELSB = 3;
    localparam int CH_ELSA = 2;
    localparam logic [1:0] CLK_OFF = 2'h0;
    localparam logic [1:0] CLK_BUS = 2'h1;
    localparam logic [1:0] CLK_FIX = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [1:0] ELS_RISE = 2'h1;
    localparam logic [1:0] ELS_FALL = 2'h2;
    localparam logic [1:0] ELS_ANY = 2'h3;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [1:0] {TPC_CAP, TPC_OC, TPC_EDGE_PWM, TPC_CENTERED_PWM} tpc_mode_e;
    function automatic logic [5:0] tpc_ch_idx(input int c, input int s);
        return 6'(int'(IDX_CH0) + CH_STRIDE * c + s);
    endfunction
endpackage

// >>> design/tpc_sync.sv
// two-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous to hclk
module tpc_sync import tpc_pkg::*; #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // async in, synced out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tpc_sync_s;
    tpc_sync_s st_ff;
    tpc_sync_s nxt_st;
    always_comb begin
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign q = st_ff.s2;
endmodule

// >>> design/tpc_timer.sv
// timer with capture/compare/pwm channels behind an AHB-Lite slave
// assumes byte registers in aligned words; pins pass the sync bank first
//
// Our own choices: the placing of the registers and the AHB-Lite slave port.
module tpc_timer import tpc_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // counting sources and debug
    input wire logic fix_clk_tick,
    input wire logic ext_clk_pin,
    input wire logic debug_halt_mode,
    // channel pins
    input wire logic [TPC_NCH-1:0] ch_pin_in,
    output logic [TPC_NCH-1:0] ch_pin_out,
    output logic [TPC_NCH-1:0] ch_pin_oe,
    // interrupt requests
    output logic wrap_irq,
    output logic [TPC_NCH-1:0] ch_irq
);
    localparam int N = TPC_NCH;
    typedef struct packed {
        logic hrdy;
        logic [7:0] rdata;
        logic wr_pend;
        logic [5:0] wr_idx;
        logic counter_wrap_flag;
        logic tof_arm;
        logic wrap_irq_enable;
        logic center_align_select;
        logic [1:0] clks;
        logic [15:0] cnt;
        logic down;
        logic clat;
        logic [7:0] cbuf;
        logic [15:0] modv;
        logic [15:0] mbuf;
        logic mph;
        logic mpl;
        logic ext_prev;
        logic [N-1:0] pin_prev;
        logic [N-1:0] flag;
        logic [N-1:0] arm;
        logic [N-1:0] ie;
        logic [N-1:0] msb;
        logic [N-1:0] msa;
        logic [N-1:0] elsb;
        logic [N-1:0] elsa;
        logic [N-1:0] vph;
        logic [N-1:0] vpl;
        logic [N-1:0] rlat;
        logic [N-1:0] pout;
        logic [N-1:0] poe;
        logic [N-1:0] cirq;
        logic [N-1:0][15:0] cv;
        logic [N-1:0][15:0] vbuf;
        logic [N-1:0][7:0] rbuf;
        logic wirq;
    } tpc_state_s;
    tpc_state_s st_ff;
    tpc_state_s nxt_st;

    logic [N:0] sync_q;
    logic addr_ph;
    logic a_map;
    logic [5:0] a_idx;
    logic rd_en;
    logic wr_en;
    logic [7:0] wdat;
    logic [7:0] rd_val;
    logic src;
    logic tick;
    logic [15:0] term;
    logic [15:0] term_m1;
    logic at_term;
    logic [15:0] cnt_step;
    logic step_up;
    logic wrap_ev;
    logic pwm_load;
    logic wr_cnt;
    logic [N-1:0] wr_csc;
    logic [N-1:0] wr_cvh;
    logic [N-1:0] wr_cvl;
    logic [N-1:0] rd_csc;
    logic [N-1:0] rd_cvh;
    logic [N-1:0] rd_cvl;
    logic [N-1:0] cap_ev;
    logic [N-1:0] match_ev;
    logic [N-1:0] load_ok;
    tpc_mode_e mode [N];

    tpc_sync #(.W(N + 1)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({ext_clk_pin, ch_pin_in}),
        .q(sync_q)
    );

    // bus decode; writes take one wait state so a following read sees them
    assign addr_ph = hsel & htrans[1] & hready;
    assign a_idx = haddr[7:2];
    assign a_map = (haddr[31:8] == ADDR_HI_ZERO) && (a_idx <= tpc_ch_idx(N - 1, 2));
    assign rd_en = addr_ph & ~hwrite & a_map;
    assign wr_en = st_ff.wr_pend;
    assign wdat = hwdata[7:0];
    assign wr_cnt = wr_en && (st_ff.wr_idx == IDX_CNTH || st_ff.wr_idx == IDX_CNTL);

    // counting source, frozen in debug halt
    always_comb begin
        case (st_ff.clks)
            CLK_BUS: src = 1'b1;
            CLK_FIX: src = fix_clk_tick;
            CLK_EXT: src = sync_q[N] & ~st_ff.ext_prev;
            default: src = 1'b0;
        endcase
    end
    assign tick = src & ~debug_halt_mode;
    assign term = (st_ff.modv == CNT_ZERO) ? CNT_MAX : st_ff.modv;
    assign term_m1 = term - CNT_ONE;
    assign at_term = st_ff.cnt == term;
    assign cnt_step = ~st_ff.center_align_select ? (at_term ? CNT_ZERO : st_ff.cnt + CNT_ONE) :
        (~st_ff.down ? (at_term ? term_m1 : st_ff.cnt + CNT_ONE) :
        (st_ff.cnt == CNT_ZERO ? CNT_ONE : st_ff.cnt - CNT_ONE));
    assign step_up = cnt_step > st_ff.cnt;
    assign wrap_ev = tick & at_term & (~st_ff.center_align_select | ~st_ff.down) & ~wr_cnt;
    assign pwm_load = tick && st_ff.cnt == term_m1 && cnt_step == term;

    // per-channel decode and events
    always_comb begin
        for (int c = 0; c < N; c++) begin
            if (st_ff.center_align_select) begin
                mode[c] = TPC_CENTERED_PWM;
            end else if (st_ff.msb[c]) begin
                mode[c] = TPC_EDGE_PWM;
            end else if (st_ff.msa[c]) begin
                mode[c] = TPC_OC;
            end else begin
                mode[c] = TPC_CAP;
            end
            wr_csc[c] = wr_en && st_ff.wr_idx == tpc_ch_idx(c, 0);
            wr_cvh[c] = wr_en && st_ff.wr_idx == tpc_ch_idx(c, 1);
            wr_cvl[c] = wr_en && st_ff.wr_idx == tpc_ch_idx(c, 2);
            rd_csc[c] = rd_en && a_idx == tpc_ch_idx(c, 0);
            rd_cvh[c] = rd_en && a_idx == tpc_ch_idx(c, 1);
            rd_cvl[c] = rd_en && a_idx == tpc_ch_idx(c, 2);
            case ({st_ff.elsb[c], st_ff.elsa[c]})
                ELS_RISE: cap_ev[c] = sync_q[c] & ~st_ff.pin_prev[c];
                ELS_FALL: cap_ev[c] = ~sync_q[c] & st_ff.pin_prev[c];
                ELS_ANY: cap_ev[c] = sync_q[c] ^ st_ff.pin_prev[c];
                default: cap_ev[c] = 1'b0;
            endcase
            cap_ev[c] = cap_ev[c] & (mode[c] == TPC_CAP);
            match_ev[c] = tick && !wr_cnt && mode[c] != TPC_CAP && cnt_step == st_ff.cv[c];
            case (mode[c])
                TPC_OC: load_ok[c] = st_ff.clks == CLK_OFF || tick;
                TPC_EDGE_PWM, TPC_CENTERED_PWM: load_ok[c] = st_ff.clks == CLK_OFF || pwm_load;
                default: load_ok[c] = st_ff.clks == CLK_OFF;
            endcase
        end
    end

    // read mux; a buffered half is returned unless debug halt freezes the latch
    always_comb begin
        rd_val = BYTE_ZERO;
        case (a_idx)
            IDX_SC: begin
                rd_val[SC_FLAG] = st_ff.counter_wrap_flag;
                rd_val[SC_IE] = st_ff.wrap_irq_enable;
                rd_val[SC_CENTER_ALIGN_SELECT] = st_ff.center_align_select;
                rd_val[SC_CLKS +: 2] = st_ff.clks;
            end
            IDX_CNTH: rd_val = (st_ff.clat && !debug_halt_mode) ? st_ff.cbuf : st_ff.cnt[15:8];
            IDX_CNTL: rd_val = (st_ff.clat && !debug_halt_mode) ? st_ff.cbuf : st_ff.cnt[7:0];
            IDX_MODH: rd_val = st_ff.modv[15:8];
            IDX_MODL: rd_val = st_ff.modv[7:0];
            default: rd_val = BYTE_ZERO;
        endcase
        for (int c = 0; c < N; c++) begin
            if (a_idx == tpc_ch_idx(c, 0)) begin
                rd_val[CH_FLAG] = st_ff.flag[c];
                rd_val[CH_IE] = st_ff.ie[c];
                rd_val[CH_MSB] = st_ff.msb[c];
                rd_val[CH_MSA] = st_ff.msa[c];
                rd_val[CH_ELSB] = st_ff.elsb[c];
                rd_val[CH_ELSA] = st_ff.elsa[c];
            end else if (a_idx == tpc_ch_idx(c, 1)) begin
                rd_val = (st_ff.rlat[c] && !debug_halt_mode) ? st_ff.rbuf[c] : st_ff.cv[c][15:8];
            end else if (a_idx == tpc_ch_idx(c, 2)) begin
                rd_val = (st_ff.rlat[c] && !debug_halt_mode) ? st_ff.rbuf[c] : st_ff.cv[c][7:0];
            end
        end
        if (!a_map) begin
            rd_val = BYTE_ZERO;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.hrdy = 1'b1;
        nxt_st.wr_pend = 1'b0;
        nxt_st.ext_prev = sync_q[N];
        nxt_st.pin_prev = sync_q[N-1:0];
        if (addr_ph) begin
            nxt_st.wr_pend = hwrite;
            nxt_st.hrdy = ~hwrite;
            nxt_st.wr_idx = a_map ? a_idx : IDX_NONE;
            if (!hwrite) begin
                nxt_st.rdata = rd_val;
            end
        end
        // timer status/control
        if (rd_en && a_idx == IDX_SC && st_ff.counter_wrap_flag) begin
            nxt_st.tof_arm = 1'b1;
        end
        if (wr_en && st_ff.wr_idx == IDX_SC) begin
            if (!hwdata[SC_FLAG] && st_ff.tof_arm) begin
                nxt_st.counter_wrap_flag = 1'b0;
                nxt_st.tof_arm = 1'b0;
            end
            nxt_st.wrap_irq_enable = hwdata[SC_IE];
            nxt_st.center_align_select = hwdata[SC_CENTER_ALIGN_SELECT];
            nxt_st.clks = hwdata[SC_CLKS +: 2];
            nxt_st.mph = 1'b0;
            nxt_st.mpl = 1'b0;
        end
        // counter and its read coherency
        if (tick) begin
            nxt_st.cnt = cnt_step;
            nxt_st.down = st_ff.center_align_select & ~step_up;
        end
        if (rd_en && (a_idx == IDX_CNTH || a_idx == IDX_CNTL) && !debug_halt_mode) begin
            nxt_st.clat = ~st_ff.clat;
            nxt_st.cbuf = (a_idx == IDX_CNTH) ? st_ff.cnt[7:0] : st_ff.cnt[15:8];
        end
        if (wr_cnt) begin
            nxt_st.cnt = CNT_ZERO;
            nxt_st.down = 1'b0;
            nxt_st.clat = 1'b0;
        end
        if (wrap_ev) begin
            nxt_st.counter_wrap_flag = 1'b1;
            nxt_st.tof_arm = 1'b0;
        end
        // modulus, buffered until both halves are written
        if (st_ff.mph && st_ff.mpl && (st_ff.clks == CLK_OFF || tick)) begin
            nxt_st.modv = st_ff.mbuf;
            nxt_st.mph = 1'b0;
            nxt_st.mpl = 1'b0;
        end
        if (wr_en && st_ff.wr_idx == IDX_MODH) begin
            nxt_st.mbuf[15:8] = wdat;
            nxt_st.mph = 1'b1;
        end
        if (wr_en && st_ff.wr_idx == IDX_MODL) begin
            nxt_st.mbuf[7:0] = wdat;
            nxt_st.mpl = 1'b1;
        end
        for (int c = 0; c < N; c++) begin
            if (st_ff.vph[c] && st_ff.vpl[c] && load_ok[c]) begin
                nxt_st.cv[c] = st_ff.vbuf[c];
                nxt_st.vph[c] = 1'b0;
                nxt_st.vpl[c] = 1'b0;
            end
            // debug halt bypasses the buffer so the sequence in flight survives
            if (mode[c] != TPC_CAP) begin
                if (wr_cvh[c] && debug_halt_mode) begin
                    nxt_st.cv[c][15:8] = wdat;
                end else if (wr_cvh[c]) begin
                    nxt_st.vbuf[c][15:8] = wdat;
                    nxt_st.vph[c] = 1'b1;
                end
                if (wr_cvl[c] && debug_halt_mode) begin
                    nxt_st.cv[c][7:0] = wdat;
                end else if (wr_cvl[c]) begin
                    nxt_st.vbuf[c][7:0] = wdat;
                    nxt_st.vpl[c] = 1'b1;
                end
            end
            if ((rd_cvh[c] || rd_cvl[c]) && !debug_halt_mode) begin
                nxt_st.rlat[c] = ~st_ff.rlat[c];
                nxt_st.rbuf[c] = rd_cvh[c] ? st_ff.cv[c][7:0] : st_ff.cv[c][15:8];
            end
            if (rd_csc[c] && st_ff.flag[c]) begin
                nxt_st.arm[c] = 1'b1;
            end
            if (wr_csc[c]) begin
                if (!hwdata[CH_FLAG] && st_ff.arm[c]) begin
                    nxt_st.flag[c] = 1'b0;
                    nxt_st.arm[c] = 1'b0;
                end
                nxt_st.ie[c] = hwdata[CH_IE];
                nxt_st.msb[c] = hwdata[CH_MSB];
                nxt_st.msa[c] = hwdata[CH_MSA];
                nxt_st.elsb[c] = hwdata[CH_ELSB];
                nxt_st.elsa[c] = hwdata[CH_ELSA];
                nxt_st.vph[c] = 1'b0;
                nxt_st.vpl[c] = 1'b0;
                nxt_st.rlat[c] = 1'b0;
            end
            if (cap_ev[c]) begin
                nxt_st.cv[c] = st_ff.cnt;
            end
            if (cap_ev[c] || match_ev[c]) begin
                nxt_st.flag[c] = 1'b1;
                nxt_st.arm[c] = 1'b0;
            end
            // pin drive
            nxt_st.poe[c] = (mode[c] != TPC_CAP) && (st_ff.elsb[c] || st_ff.elsa[c]);
            case (mode[c])
                TPC_OC: begin
                    if (match_ev[c]) begin
                        case ({st_ff.elsb[c], st_ff.elsa[c]})
                            ELS_RISE: nxt_st.pout[c] = ~st_ff.pout[c];
                            ELS_FALL: nxt_st.pout[c] = 1'b0;
                            ELS_ANY: nxt_st.pout[c] = 1'b1;
                            default: nxt_st.pout[c] = st_ff.pout[c];
                        endcase
                    end
                end
                TPC_EDGE_PWM: begin
                    if (match_ev[c]) begin
                        nxt_st.pout[c] = st_ff.elsa[c];
                    end else if (wrap_ev) begin
                        nxt_st.pout[c] = ~st_ff.elsa[c];
                    end
                end
                TPC_CENTERED_PWM: begin
                    if (st_ff.cv[c] == CNT_ZERO || st_ff.cv[c][15]) begin
                        nxt_st.pout[c] = st_ff.elsa[c];
                    end else if (st_ff.cv[c] > term) begin
                        nxt_st.pout[c] = ~st_ff.elsa[c];
                    end else if (match_ev[c]) begin
                        nxt_st.pout[c] = step_up ? st_ff.elsa[c] : ~st_ff.elsa[c];
                    end
                end
                default: nxt_st.pout[c] = 1'b0;
            endcase
            nxt_st.cirq[c] = nxt_st.flag[c] & nxt_st.ie[c];
        end
        nxt_st.wirq = nxt_st.counter_wrap_flag & nxt_st.wrap_irq_enable;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
            st_ff.hrdy <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata = {24'h000000, st_ff.rdata};
    assign hreadyout = st_ff.hrdy;
    assign hresp = 1'b0;
    assign ch_pin_out = st_ff.pout;
    assign ch_pin_oe = st_ff.poe;
    assign wrap_irq = st_ff.wirq;
    assign ch_irq = st_ff.cirq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_tof_read;
        rd_en && a_idx == IDX_SC && st_ff.counter_wrap_flag && !wrap_ev;
    endsequence
    sequence s_tof_zero_write;
        wr_en && st_ff.wr_idx == IDX_SC && !hwdata[SC_FLAG] && !wrap_ev;
    endsequence

    cnt_clear_a: assert property (wr_cnt |=> st_ff.cnt == CNT_ZERO && !st_ff.clat)
        else $error("counter write did not clear count");
    wrap_up_a: assert property (tick && !st_ff.center_align_select && at_term && !wr_cnt |=> st_ff.cnt == CNT_ZERO && st_ff.counter_wrap_flag)
        else $error("up count did not wrap with flag");
    center_turn_a: assert property (tick && st_ff.center_align_select && !st_ff.down && at_term && !wr_cnt
        |=> st_ff.down && st_ff.counter_wrap_flag && st_ff.cnt == $past(term_m1))
        else $error("centered turnaround wrong");
    capture_val_a: assert property (cap_ev[0] |=> st_ff.cv[0] == $past(st_ff.cnt) && st_ff.flag[0])
        else $error("capture value or flag wrong");
    cap_readonly_a: assert property (mode[0] == TPC_CAP && !cap_ev[0] |=> $stable(st_ff.cv[0]))
        else $error("capture value changed without event");
    oc_toggle_a: assert property (mode[0] == TPC_OC && st_ff.elsa[0] && !st_ff.elsb[0] && match_ev[0]
        |=> st_ff.pout[0] != $past(st_ff.pout[0]) && st_ff.flag[0])
        else $error("compare toggle missing");
    edge_pwm_zero_a: assert property (mode[0] == TPC_EDGE_PWM && st_ff.cv[0] == CNT_ZERO && !st_ff.elsa[0] && wrap_ev
        && !wr_en |=> !st_ff.pout[0])
        else $error("zero duty pwm went high");
    flag_set_wins_a: assert property (match_ev[0] || cap_ev[0] |=> st_ff.flag[0])
        else $error("channel event lost");
    tof_clear_a: assert property (s_tof_read ##1 (!wrap_ev) [*2] ##1 s_tof_zero_write |=> !st_ff.counter_wrap_flag)
        else $error("wrap flag not cleared by read then write");
    ch_irq_a: assert property (st_ff.flag[0] && st_ff.ie[0] && !wr_en |=> ch_irq[0])
        else $error("channel interrupt missing");
endmodule

// >>> tb/tpc_pin_model.sv
// far side of the channel pins: outside drive and the wired pin level
// assumes the design's oe is high while it drives its pin
module tpc_pin_model import tpc_pkg::*; (
    // outside levels
    input wire logic [TPC_NCH-1:0] drv,
    // design side of the pins
    input wire logic [TPC_NCH-1:0] ch_pin_out,
    input wire logic [TPC_NCH-1:0] ch_pin_oe,
    output logic [TPC_NCH-1:0] ch_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // a driven pin reads back its own level, else the outside level
    assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & drv);
endmodule

// >>> tb/timer_pwm_channels_bench.sv
// self-checking bench for tpc_timer: ahb-lite byte registers and pins
// assumes one slave, so hreadyout closes the bus
module timer_pwm_channels_bench import tpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [TPC_NCH-1:0] drv = 2'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [TPC_NCH-1:0] ch_pin_in;
    logic [TPC_NCH-1:0] ch_pin_out;
    logic [TPC_NCH-1:0] ch_pin_oe;
    logic hresp;
    logic wrap_irq;
    logic [TPC_NCH-1:0] ch_irq;
    int errors = 0;
    int checked = 0;
    always #25 hclk = ~hclk;
    tpc_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fix_clk_tick(1'b0), .ext_clk_pin(1'b0),
        .debug_halt_mode(1'b0), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
        .ch_pin_oe(ch_pin_oe), .wrap_irq(wrap_irq), .ch_irq(ch_irq));
    tpc_pin_model i_pins (.drv(drv), .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .ch_pin_in(ch_pin_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; flops read here still hold pre-edge values
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        bus(1'b0, a, 8'h00, v[15:8]);
        bus(1'b0, a + 8'h04, 8'h00, v[7:0]);
    endtask
    task automatic t_reset;
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h20, 8'h00);
        chk({14'h0000, ch_pin_oe}, 16'h0000);
        chk({12'h000, hresp, wrap_irq, ch_irq}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_capture;
        logic [15:0] v;
        logic [15:0] c;
        wr(8'h14, 8'h44);
        wr(8'h00, 8'h08);
        repeat (20) @(posedge hclk);
        // stop the count so the capture value is known
        wr(8'h00, 8'h00);
        rd16(8'h04, v);
        chk(16'(v != 16'h0000), 16'h0001);
        drv <= 2'h1;
        repeat (6) @(posedge hclk);
        rd16(8'h18, c);
        chk(c, v);
        rd_chk(8'h14, 8'hC4);
        chk({14'h0000, ch_irq}, 16'h0001);
        wr(8'h18, 8'hAB);
        rd16(8'h18, c);
        chk(c, v);
        drv <= 2'h0;
        $display("test capture done");
    endtask
    task automatic t_wrap;
        logic [15:0] v;
        wr(8'h0C, 8'h00);
        wr(8'h10, 8'h03);
        // count stopped above the new modulus would run to the top first
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h48);
        repeat (12) @(posedge hclk);
        rd_chk(8'h00, 8'hC8);
        chk({15'h0000, wrap_irq}, 16'h0001);
        // a wrap between read and write keeps the flag, so stop first, writing the flag as one
        wr(8'h00, 8'hC0);
        rd_chk(8'h00, 8'hC0);
        wr(8'h00, 8'h40);
        rd_chk(8'h00, 8'h40);
        chk({15'h0000, wrap_irq}, 16'h0000);
        rd16(8'h04, v);
        chk(16'(v <= 16'h0003), 16'h0001);
        wr(8'h04, 8'h5A);
        rd16(8'h04, v);
        chk(v, 16'h0000);
        $display("test wrap done");
    endtask
    task automatic t_edge_pwm;
        logic [7:0] val [3] = '{8'h00, 8'h01, 8'h04};
        logic [15:0] exp [3] = '{16'h0000, 16'h0002, 16'h0008};
        logic [15:0] hi;
        for (int i = 0; i < 3; i++) begin
            // clock off so the new duty loads on the second byte
            wr(8'h00, 8'h00);
            wr(8'h14, 8'h28);
            wr(8'h18, 8'h00);
            wr(8'h1C, val[i]);
            wr(8'h00, 8'h08);
            repeat (6) @(posedge hclk);
            hi = 16'h0000;
            // two whole periods of modulus plus one
            repeat (8) begin
                @(posedge hclk);
                hi += {15'h0000, ch_pin_out[0]};
            end
            chk(hi, exp[i]);
            chk({15'h0000, ch_pin_oe[0]}, 16'h0001);
        end
        $display("test edge pwm done");
    endtask
    task automatic t_centered_pwm;
        logic [15:0] hi;
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h00);
        wr(8'h18, 8'h00);
        wr(8'h1C, 8'h01);
        wr(8'h00, 8'h28);
        repeat (6) @(posedge hclk);
        hi = 16'h0000;
        // two periods of twice the modulus, pulse twice the value each
        repeat (12) begin
            @(posedge hclk);
            hi += {15'h0000, ch_pin_out[0]};
        end
        chk(hi, 16'h0004);
        $display("test centered pwm done");
    endtask
    task automatic t_compare;
        logic p;
        logic [15:0] n;
        wr(8'h00, 8'h00);
        wr(8'h14, 8'h14);
        wr(8'h18, 8'h00);
        wr(8'h1C, 8'h01);
        wr(8'h00, 8'h08);
        repeat (6) @(posedge hclk);
        n = 16'h0000;
        p = ch_pin_out[0];
        // eight steps hold exactly two matches at a period of four
        repeat (8) begin
            @(posedge hclk);
            n += {15'h0000, ch_pin_out[0] ^ p};
            p = ch_pin_out[0];
        end
        chk(n, 16'h0002);
        $display("test compare done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_capture;
        t_wrap;
        t_edge_pwm;
        t_centered_pwm;
        t_compare;
        report_and_stop;
    end
    // all tests take well under a thousand cycles
    initial begin
        #2000000;
        errors++;
        report_and_stop;
    end
endmodule
